/* File: pslat_pkg.sv */
// Purpose: Shared types and constants for the previous-settings latch.
// Assumes: 25 MHz core clock; 16-bit register images.
// Notes:   Struct layouts give the field positions of each register.
package pslat_pkg;

  localparam int CLK_MHZ       = 25;
  localparam int VALID_TIME_US = 1000;
  localparam int VALID_CYC     = VALID_TIME_US * CLK_MHZ;
  localparam int CNT_W         = 15;
  localparam int NUM_CH_MAX    = 4;

  localparam logic [7:0]  ADDR_PREVIOUS_CONTROL_SETTINGS  = 8'h23;
  localparam logic [7:0]  ADDR_RANGE_LAT = 8'h24;
  localparam logic [15:0] CTRL_RST_4CH   = 16'h0700;
  localparam logic [15:0] RANGE_RST      = 16'h0000;
  localparam logic [15:0] UNMAPPED_DATA  = 16'h0000;

  localparam logic [3:0] OFF_DEF_4CH = 4'h0;
  localparam logic [3:0] OFF_DEF_3CH = 4'h1;
  localparam logic [3:0] OFF_DEF_2CH = 4'h3;
  localparam logic [3:0] OFF_DEF_1CH = 4'h7;

  typedef enum logic [3:0] {
    MODE_ADPT_1024 = 4'h0,
    MODE_ADPT_256  = 4'h1,
    MODE_ADPT_64   = 4'h2,
    MODE_ADPT_8    = 4'h3,
    MODE_CONT_1024 = 4'h4,
    MODE_CONT_256  = 4'h5,
    MODE_CONT_64   = 4'h6,
    MODE_CONT_8    = 4'h7,
    MODE_SINGLE    = 4'h8,
    MODE_SINGLE_8X = 4'h9,
    MODE_FAST      = 4'ha,
    MODE_BURST     = 4'hb,
    MODE_RSVD_LO   = 4'hc,
    MODE_RSVD_HI   = 4'he,
    MODE_SLEEP     = 4'hf
  } pslat_mode_e;

  typedef enum logic [1:0] {
    PIN_ALERT    = 2'h0,
    PIN_GPIO_IN  = 2'h1,
    PIN_GPIO_OUT = 2'h2,
    PIN_SLOW     = 2'h3
  } pslat_pin_e;

  localparam logic [1:0] RNG_UNI      = 2'h0;
  localparam logic [1:0] RNG_BI_FULL  = 2'h1;
  localparam logic [1:0] RNG_BI_HALF  = 2'h2;
  localparam logic [1:0] RNG_RESERVED = 2'h3;

  typedef struct packed {
    logic [3:0] sample_mode;
    logic [1:0] pin2_function_select;
    logic [1:0] pin1_function_select;
    logic [3:0] chan_off;
    logic [3:0] unused;
  } pslat_ctrl_s;

  typedef struct packed {
    logic [1:0] sense_range_ch1;
    logic [1:0] sense_range_ch2;
    logic [1:0] sense_range_ch3;
    logic [1:0] sense_range_ch4;
    logic [1:0] bus_range_ch1;
    logic [1:0] bus_range_ch2;
    logic [1:0] bus_range_ch3;
    logic [1:0] bus_range_ch4;
  } pslat_range_s;

  typedef struct packed {
    logic [1:0] din;
    logic [1:0] dout;
    logic [1:0] oe;
  } pslat_pins_s;

  typedef enum logic [2:0] {
    VS_NONE  = 3'b001,
    VS_WAIT  = 3'b010,
    VS_VALID = 3'b100
  } pslat_vstate_e;

  typedef struct packed {
    pslat_vstate_e vstate;
    logic [CNT_W-1:0] cnt;
    pslat_ctrl_s   act_ctrl;
    pslat_range_s  act_range;
    logic [3:0]    pend_mode;
    logic          pend_on;
    pslat_ctrl_s   lat_ctrl;
    pslat_range_s  lat_range;
    logic [1:0]    pin_s1;
    logic [1:0]    pin_s2;
    logic [1:0]    pin_out;
    logic [1:0]    pin_oe;
    logic [15:0]   rd_data;
    logic          rd_ack;
  } pslat_state_s;

endpackage : pslat_pkg

/* File: pslat_top.sv */
// Purpose: Active settings copy and the latch of the settings in force
//          before the last commit, with a register read port.
// Assumes: commit_stb is one pulse per commit of any variant.
// Notes:   Programmed copies, conversion engine and alert status live
//          outside; this block only holds and steers from settings.
`timescale 1ns/100ps

module pslat_top #(
  parameter int unsigned NUM_CH       = 4,
  parameter int unsigned VALID_CYCLES = pslat_pkg::VALID_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   commit_stb,
  input  wire pslat_pkg::pslat_ctrl_s  prog_ctrl,
  input  wire pslat_pkg::pslat_range_s prog_range,
  input  wire logic                   conv_cycle_done,
  input  wire logic                   skip_inhibit,
  input  wire logic [1:0]             alert_req,
  input  wire logic [1:0]             gpio_out_data,
  input  wire logic [1:0]             pin_in,
  output logic [1:0]                  pin_out,
  output logic [1:0]                  pin_oe,
  output logic [1:0]                  gpio_in_data,
  input  wire logic                   reg_rd,
  input  wire logic [7:0]             reg_addr,
  output logic [15:0]                 rd_data,
  output logic                        rd_ack,
  output pslat_pkg::pslat_ctrl_s      active_ctrl,
  output pslat_pkg::pslat_range_s     active_range,
  output logic                        lat_valid,
  output logic [3:0]                  eff_mode,
  output logic                        sampling_on,
  output logic [3:0]                  chan_conv_en,
  output logic [3:0]                  ptr_skip
);

  import pslat_pkg::*;

  function automatic logic [3:0] off_default(input int unsigned n);
    logic [3:0] v;
    v = OFF_DEF_4CH;
    case (n)
      1: v = OFF_DEF_1CH;
      2: v = OFF_DEF_2CH;
      3: v = OFF_DEF_3CH;
      default: v = OFF_DEF_4CH;
    endcase
    return v;
  endfunction : off_default

  function automatic logic mode_reserved(input logic [3:0] m);
    return (m >= MODE_RSVD_LO) && (m <= MODE_RSVD_HI);
  endfunction : mode_reserved

  function automatic logic mode_throttles(input logic [3:0] m);
    return (m <= MODE_CONT_8) || (m == MODE_FAST) || (m == MODE_BURST);
  endfunction : mode_throttles

  localparam pslat_ctrl_s CTRL_RST = CTRL_RST_4CH |
    (16'(off_default(NUM_CH)) << 4);
  localparam logic [CNT_W-1:0] VALID_LAST = CNT_W'(VALID_CYCLES - 1);

  logic [1:0] rst_q;
  logic       rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  pslat_state_s st_r;
  pslat_state_s st_nxt;
  pslat_ctrl_s  new_ctrl;
  pslat_range_s new_range;
  logic [7:0][1:0] rng_old;
  logic [7:0][1:0] rng_new;
  logic [7:0][1:0] rng_flt;
  logic [3:0]   cur_mode;
  logic [3:0]   tgt_mode;
  logic         slow_hit;
  logic [1:0]   pin_fn [2];

  // Reserved range codes are refused per field; old field stays in force
  assign rng_old = st_r.act_range;
  assign rng_new = prog_range;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_rng
      assign rng_flt[gi] = (rng_new[gi] == RNG_RESERVED) ?
                           rng_old[gi] : rng_new[gi];
    end
  endgenerate
  assign new_range = rng_flt;

  assign cur_mode = st_r.act_ctrl.sample_mode;
  // A reserved mode code never becomes active
  assign tgt_mode = mode_reserved(prog_ctrl.sample_mode) ?
                    cur_mode : prog_ctrl.sample_mode;

  always_comb begin
    new_ctrl                      = prog_ctrl;
    new_ctrl.sample_mode          = cur_mode;
    new_ctrl.unused               = 4'h0;
  end

  assign pin_fn[0] = st_r.act_ctrl.pin1_function_select;
  assign pin_fn[1] = st_r.act_ctrl.pin2_function_select;
  assign slow_hit  = ((pin_fn[0] == PIN_SLOW) && st_r.pin_s2[0]) ||
                     ((pin_fn[1] == PIN_SLOW) && st_r.pin_s2[1]);

  always_comb begin
    st_nxt        = st_r;
    st_nxt.pin_s1 = pin_in;
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.rd_ack = 1'b0;

    // Deferred rate change lands when the running cycle ends
    if (st_r.pend_on && conv_cycle_done) begin
      st_nxt.act_ctrl.sample_mode = st_r.pend_mode;
      st_nxt.pend_on              = 1'b0;
    end

    case (st_r.vstate)
      VS_NONE: begin
        st_nxt.cnt = '0;
      end
      VS_WAIT: begin
        st_nxt.cnt = st_r.cnt + CNT_W'(1);
        if (st_r.cnt == VALID_LAST) begin
          st_nxt.vstate = VS_VALID;
          st_nxt.cnt    = '0;
        end
      end
      VS_VALID: begin
        st_nxt.cnt = '0;
      end
      default: begin
        st_nxt.vstate = VS_NONE;
        st_nxt.cnt    = '0;
      end
    endcase

    if (commit_stb) begin
      // Capture and transfer share this edge so the latch is the old active copy
      st_nxt.lat_ctrl  = st_r.act_ctrl;
      st_nxt.lat_range = st_r.act_range;
      st_nxt.lat_ctrl.unused = 4'h0;
      st_nxt.act_range = new_range;
      st_nxt.act_ctrl  = new_ctrl;
      // Sleep runs no cycle, so a change out of it need not wait
      if (tgt_mode == cur_mode) begin
        st_nxt.pend_on = 1'b0;
      end else if (cur_mode == MODE_SLEEP || conv_cycle_done) begin
        st_nxt.act_ctrl.sample_mode = tgt_mode;
        st_nxt.pend_on              = 1'b0;
      end else begin
        st_nxt.pend_mode = tgt_mode;
        st_nxt.pend_on   = 1'b1;
      end
      st_nxt.vstate = VS_WAIT;
      st_nxt.cnt    = '0;
    end

    // Pin drivers: alert is open drain, gpio output is push-pull
    for (int i = 0; i < 2; i++) begin
      case (pin_fn[i])
        PIN_ALERT: begin
          st_nxt.pin_out[i] = 1'b0;
          st_nxt.pin_oe[i]  = alert_req[i];
        end
        PIN_GPIO_OUT: begin
          st_nxt.pin_out[i] = gpio_out_data[i];
          st_nxt.pin_oe[i]  = 1'b1;
        end
        default: begin
          st_nxt.pin_out[i] = 1'b0;
          st_nxt.pin_oe[i]  = 1'b0;
        end
      endcase
    end

    if (reg_rd) begin
      st_nxt.rd_ack = 1'b1;
      case (reg_addr)
        ADDR_PREVIOUS_CONTROL_SETTINGS: begin
          st_nxt.rd_data = {st_r.lat_ctrl[15:4], 4'h0};
        end
        ADDR_RANGE_LAT: begin
          st_nxt.rd_data = st_r.lat_range;
        end
        default: begin
          st_nxt.rd_data = UNMAPPED_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r           <= '0;
      st_r.vstate    <= VS_NONE;
      st_r.act_ctrl  <= CTRL_RST;
      st_r.act_range <= RANGE_RST;
      st_r.lat_ctrl  <= CTRL_RST;
      st_r.lat_range <= RANGE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Rate decode: low two bits pick 1024/256/64/8 SPS inside each family
  always_comb begin
    eff_mode    = cur_mode;
    sampling_on = 1'b1;
    case (cur_mode)
      MODE_ADPT_1024, MODE_ADPT_256,
      MODE_ADPT_64, MODE_ADPT_8: begin
        eff_mode = slow_hit ? MODE_ADPT_8 : cur_mode;
      end
      MODE_CONT_1024, MODE_CONT_256,
      MODE_CONT_64, MODE_CONT_8: begin
        eff_mode = slow_hit ? MODE_CONT_8 : cur_mode;
      end
      MODE_FAST, MODE_BURST: begin
        eff_mode = (slow_hit && mode_throttles(cur_mode)) ?
                   MODE_CONT_8 : cur_mode;
      end
      MODE_SINGLE, MODE_SINGLE_8X: begin
        eff_mode = cur_mode;
      end
      default: begin
        eff_mode    = MODE_SLEEP;
        sampling_on = 1'b0;
      end
    endcase
  end

  assign chan_conv_en = sampling_on ?
                        ~st_r.act_ctrl.chan_off : 4'h0;
  assign ptr_skip     = skip_inhibit ?
                        4'h0 : st_r.act_ctrl.chan_off;

  assign active_ctrl  = st_r.act_ctrl;
  assign active_range = st_r.act_range;
  assign lat_valid    = (st_r.vstate == VS_VALID);
  assign gpio_in_data = st_r.pin_s2;
  assign pin_out      = st_r.pin_out;
  assign pin_oe       = st_r.pin_oe;
  assign rd_data      = st_r.rd_data;
  assign rd_ack       = st_r.rd_ack;

endmodule : pslat_top

/* File: pslat_asserts.sv */
// Purpose: Port-level checks of the previous-settings latch.
// Assumes: commit_stb is a one-cycle pulse; reads are single strobes.
// Notes:   Helper logic remembers the active copy at each commit.
`timescale 1ns/100ps
module pslat_asserts #(
  parameter int unsigned VALID_CYCLES = pslat_pkg::VALID_CYC
) (
  input wire logic                   clk,
  input wire logic                   arst_n,
  input wire logic                   commit_stb,
  input wire pslat_pkg::pslat_ctrl_s  prog_ctrl,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_addr,
  input wire logic [15:0]            rd_data,
  input wire logic                   rd_ack,
  input wire pslat_pkg::pslat_ctrl_s  active_ctrl,
  input wire pslat_pkg::pslat_range_s active_range,
  input wire logic                   lat_valid,
  input wire logic [3:0]             eff_mode,
  input wire logic                   sampling_on,
  input wire logic [1:0]             gpio_out_data,
  input wire logic [1:0]             pin_out,
  input wire logic [1:0]             pin_oe
);
  import pslat_pkg::*;
  logic [15:0]  cyc_r;
  logic         seen_r;
  pslat_ctrl_s  old_ctrl_r;
  pslat_range_s old_rng_r;

  // Saturates so a long idle stretch never wraps into a false match
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_r      <= 16'h0;
      seen_r     <= 1'b0;
      old_ctrl_r <= CTRL_RST_4CH;
      old_rng_r  <= RANGE_RST;
    end else if (commit_stb) begin
      cyc_r      <= 16'h1;
      seen_r     <= 1'b1;
      old_ctrl_r <= active_ctrl;
      old_rng_r  <= active_range;
    end else if (cyc_r != 16'hffff) begin
      cyc_r <= cyc_r + 16'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_rd(logic [7:0] a);
    reg_rd && reg_addr == a && !commit_stb;
  endsequence

  a_read_ack: assert property (reg_rd |=> rd_ack)
    else $error("read not acknowledged");
  a_ack_cause: assert property (rd_ack |-> $past(reg_rd))
    else $error("acknowledge without read");
  a_ctrl_prior: assert property (s_rd(ADDR_PREVIOUS_CONTROL_SETTINGS) |=>
    rd_data[15:4] == old_ctrl_r[15:4] && rd_data[3:0] == 4'h0)
    else $error("control latch not prior active value");
  a_range_prior: assert property (s_rd(ADDR_RANGE_LAT) |=> rd_data == old_rng_r)
    else $error("range latch not prior active value");
  a_valid_clr: assert property (commit_stb |=> !lat_valid [*8])
    else $error("valid flag not cleared by commit");
  a_valid_time: assert property ($rose(lat_valid) |-> cyc_r == 16'(VALID_CYCLES + 1))
    else $error("valid flag rose at wrong time");
  a_valid_late: assert property (seen_r && cyc_r == 16'(VALID_CYCLES + 1) |-> lat_valid)
    else $error("valid flag late");
  a_no_early: assert property (!seen_r |-> !lat_valid)
    else $error("valid before first commit");
  a_fields_apply: assert property (commit_stb |=>
    active_ctrl[11:4] == $past(prog_ctrl[11:4]))
    else $error("pin or channel fields not applied at commit");
  a_sleep_idle: assert property (eff_mode == MODE_SLEEP |-> !sampling_on)
    else $error("sampling in sleep");
  a_gpio_drive: assert property ($past(active_ctrl.pin2_function_select) == PIN_GPIO_OUT
    |-> pin_oe[1] && pin_out[1] == $past(gpio_out_data[1]))
    else $error("output pin not driven");
endmodule : pslat_asserts

bind pslat_top pslat_asserts #(.VALID_CYCLES(VALID_CYCLES)) i_pslat_asserts (
  .clk, .arst_n, .commit_stb, .prog_ctrl, .reg_rd, .reg_addr, .rd_data, .rd_ack,
  .active_ctrl, .active_range, .lat_valid, .eff_mode, .sampling_on,
  .gpio_out_data, .pin_out, .pin_oe
);

/* File: pslat_top_tb.sv */
// Purpose: Self-checking bench of the previous-settings latch.
// Assumes: Short valid count; pending modes resolved after each commit.
// Notes:   Random settings walk every mode code, reserved ones included.
`timescale 1ns/100ps
module pslat_top_tb;
  import pslat_pkg::*;
  localparam int unsigned VC = 20;
  logic         clk, arst_n, commit_stb, conv_cycle_done, skip_inhibit, reg_rd;
  logic         rd_ack, lat_valid, sampling_on;
  logic [1:0]   alert_req, gpio_out_data, pin_in, pin_out, pin_oe, gpio_in_data;
  logic [3:0]   eff_mode, chan_conv_en, ptr_skip, m_pend;
  logic [7:0]   reg_addr;
  logic [15:0]  rd_data;
  logic [31:0]  r;
  pslat_ctrl_s  prog_ctrl, active_ctrl, m_act, m_lat, pc;
  pslat_range_s prog_range, active_range, m_rng, m_lrng, pr;
  int           seed, failures, checks_done, i;

  pslat_top #(.NUM_CH(4), .VALID_CYCLES(VC)) i_pslat_top (
    .clk, .arst_n, .commit_stb, .prog_ctrl, .prog_range, .conv_cycle_done,
    .skip_inhibit, .alert_req, .gpio_out_data, .pin_in, .pin_out, .pin_oe,
    .gpio_in_data, .reg_rd, .reg_addr, .rd_data, .rd_ack, .active_ctrl,
    .active_range, .lat_valid, .eff_mode, .sampling_on, .chan_conv_en, .ptr_skip
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({15'h0, rd_ack}, 16'h1);
    chk(rd_data, e);
  endtask : rd

  task automatic commit(input pslat_ctrl_s c, input pslat_range_s g, input logic d);
    @(posedge clk);
    prog_ctrl       <= c;
    prog_range      <= g;
    commit_stb      <= 1'b1;
    conv_cycle_done <= d;
    @(posedge clk);
    commit_stb      <= 1'b0;
    conv_cycle_done <= 1'b0;
    m_lat  = m_act;
    m_lrng = m_rng;
    m_act[11:4] = c[11:4];
    m_pend = m_act.sample_mode;
    // Reserved mode codes are refused, the prior mode stays
    if (c.sample_mode < 4'hc || c.sample_mode == 4'hf) begin
      m_pend = c.sample_mode;
      if (d || m_act.sample_mode == 4'hf || m_act.sample_mode == c.sample_mode)
        m_act.sample_mode = c.sample_mode;
    end
    for (int k = 0; k < 16; k += 2)
      if (g[k+:2] != RNG_RESERVED) m_rng[k+:2] = g[k+:2];
  endtask : commit

  function automatic logic [3:0] exp_eff(input pslat_ctrl_s c, input logic [1:0] p);
    if (!((c.pin1_function_select == PIN_SLOW && p[0]) ||
          (c.pin2_function_select == PIN_SLOW && p[1])) ||
        c.sample_mode inside {4'h8, 4'h9, 4'hf}) return c.sample_mode;
    return (c.sample_mode < 4'h4) ? 4'h3 : 4'h7;
  endfunction : exp_eff

  function automatic logic [1:0] exp_pin(input logic [1:0] f, input logic a, input logic g);
    case (f)
      PIN_ALERT:    return {a, 1'b0};
      PIN_GPIO_OUT: return {1'b1, g};
      default:      return 2'h0;
    endcase
  endfunction : exp_pin

  task automatic chk_outs;
    chk({active_ctrl[15:4], 4'h0}, m_act);
    chk(active_range, m_rng);
    chk({12'h0, eff_mode}, {12'h0, exp_eff(m_act, pin_in)});
    chk({15'h0, sampling_on}, {15'h0, m_act.sample_mode != 4'hf});
    // No channel converts while asleep
    chk({12'h0, chan_conv_en}, {12'h0, (m_act.sample_mode == 4'hf) ?
      4'h0 : ~m_act.chan_off});
    chk({12'h0, ptr_skip}, {12'h0, skip_inhibit ? 4'h0 : m_act.chan_off});
    chk({10'h0, pin_oe, pin_out, gpio_in_data}, {10'h0,
      exp_pin(m_act.pin2_function_select, alert_req[1], gpio_out_data[1]) & 2'h2 |
      exp_pin(m_act.pin1_function_select, alert_req[0], gpio_out_data[0]) >> 1, 
      exp_pin(m_act.pin2_function_select, alert_req[1], gpio_out_data[1]) << 1 & 2'h2 |
      exp_pin(m_act.pin1_function_select, alert_req[0], gpio_out_data[0]) & 2'h1, pin_in});
  endtask : chk_outs

  task automatic finish_test;
    $display("Checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    finish_test;
  end

  initial begin
    seed = 94122;
    {arst_n, commit_stb, conv_cycle_done, skip_inhibit, reg_rd} = 5'h0;
    {alert_req, gpio_out_data, pin_in, reg_addr} = 14'h0;
    prog_ctrl  = CTRL_RST_4CH;
    prog_range = RANGE_RST;
    m_act = CTRL_RST_4CH;
    m_rng = RANGE_RST;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({15'h0, lat_valid}, 16'h0);
    chk_outs;
    rd(ADDR_PREVIOUS_CONTROL_SETTINGS, CTRL_RST_4CH);
    rd(ADDR_RANGE_LAT, RANGE_RST);
    rd(8'h25, UNMAPPED_DATA);
    for (i = 0; i < 24; i++) begin
      pc = 16'($random(seed));
      pc.sample_mode = (i < 16) ? 4'(i) : pc.sample_mode;
      pr = 16'($random(seed));
      r  = $random(seed);
      @(posedge clk);
      {pin_in, alert_req, gpio_out_data} <= r[5:0];
      skip_inhibit <= r[6];
      commit(pc, pr, r[7]);
      if (i % 4 == 3) commit(pc, pr, 1'b1);
      #1;
      chk({15'h0, lat_valid}, 16'h0);
      rd(ADDR_PREVIOUS_CONTROL_SETTINGS, m_lat);
      rd(ADDR_RANGE_LAT, m_lrng);
      chk_outs;
      @(posedge clk);
      conv_cycle_done <= 1'b1;
      @(posedge clk);
      conv_cycle_done <= 1'b0;
      m_act.sample_mode = m_pend;
      @(posedge clk);
      #1;
      chk_outs;
      repeat (VC - 8) @(posedge clk);
      #1;
      chk({15'h0, lat_valid}, 16'h0);
      @(posedge clk);
      #1;
      chk({15'h0, lat_valid}, 16'h1);
    end
    finish_test;
  end
endmodule : pslat_top_tb
